// ---- pkg/topo_cfg.svh ----
`ifndef TOPO_CFG_SVH
`define TOPO_CFG_SVH

// register byte offsets
`define OFF_CTRL 12'hF00
`define OFF_OUT_OVR 12'hEF8
`define OFF_IN_LEVEL 12'hEFC
`define OFF_LINK_STAT 12'hEF0
`define OFF_ALT_COUNT 12'hEE0
`define OFF_ALT_SELECT 12'hEE4

// field positions
`define IME_BIT 0
`define ALT_W 5

// reset values
`define RST_OVR 1'b0
`define RST_SELECT 5'h00
`define RST_RDATA 32'h0000_0000

`endif

// ---- pkg/topo_pkg.sv ----
package topo_pkg;

    typedef enum logic [1:0]
    {
        MODE_FUNC = 2'b01,
        MODE_DETECT = 2'b10
    } mode_t;

endpackage

// ---- rtl/level_sync.sv ----
`timescale 1ns/1ps

// three-stage synchroniser; a change is passed on only once stages two and
// three agree, so a single-cycle metastable settle never reaches the output
module level_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] agree;

    assign agree = ~(stage2 ^ stage3);

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            dout <= '0;
        end
        else
        begin
            stage1 <= din;
            stage2 <= stage1;
            stage3 <= stage2;
            dout <= (agree & stage3) | (~agree & dout);
        end
    end

endmodule

// ---- rtl/topo_detect.sv ----
`timescale 1ns/1ps

`include "topo_cfg.svh"

module topo_detect
    import topo_pkg::*;
#(
    parameter int NUM_IN = 4,
    parameter int NUM_OUT = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic [NUM_IN-1:0] det_in,
    output logic [NUM_IN-1:0] func_in,
    input wire logic [NUM_OUT-1:0] func_out,
    output logic [NUM_OUT-1:0] det_out,
    input wire logic [NUM_IN-1:0] link_connected,
    input wire logic [`ALT_W-1:0] alt_count,
    output logic [`ALT_W-1:0] alt_select,
    output logic detect_mode
);

    mode_t mode;
    mode_t next_mode;
    logic [NUM_OUT-1:0] out_ovr;
    logic [NUM_OUT-1:0] next_out_ovr;
    logic [NUM_IN-1:0] in_level;
    logic [NUM_IN-1:0] link_level;
    logic [`ALT_W-1:0] next_alt_select;
    logic [31:0] next_rdata;

    // address decode
    wire hit_ctrl = (reg_addr == `OFF_CTRL);
    wire hit_ovr = (reg_addr == `OFF_OUT_OVR);
    wire hit_in = (reg_addr == `OFF_IN_LEVEL);
    wire hit_link = (reg_addr == `OFF_LINK_STAT);
    wire hit_count = (reg_addr == `OFF_ALT_COUNT);
    wire hit_select = (reg_addr == `OFF_ALT_SELECT);

    wire wr_ctrl = reg_write & hit_ctrl;
    wire wr_ovr = reg_write & hit_ovr;
    wire wr_select = reg_write & hit_select;

    wire in_detect = (mode == MODE_DETECT);
    wire [`ALT_W-1:0] sel_req = reg_wdata[`ALT_W-1:0];
    // only values below the tied-off count name a real connection
    wire sel_valid = (sel_req < alt_count);
    // upper write bits must be zero too, or the request is out of range
    wire sel_upper_zero = (reg_wdata[31:`ALT_W] == '0);
    wire sel_take = wr_select & sel_valid & sel_upper_zero;

    wire [31:0] ctrl_word = {31'h0000_0000, in_detect};
    wire [31:0] in_word = {{(32-NUM_IN){1'b0}}, in_level};
    wire [31:0] ovr_word = {{(32-NUM_OUT){1'b0}}, out_ovr};
    wire [31:0] link_word = {{(32-NUM_IN){1'b0}}, link_level};
    wire [31:0] count_word = {{(32-`ALT_W){1'b0}}, alt_count};
    wire [31:0] select_word = {{(32-`ALT_W){1'b0}}, alt_select};

    // pins arrive unsynchronised
    level_sync #(
        .WIDTH(NUM_IN)
    ) in_sync (
        .clk(clk),
        .reset(reset),
        .din(det_in),
        .dout(in_level)
    );

    level_sync #(
        .WIDTH(NUM_IN)
    ) link_sync (
        .clk(clk),
        .reset(reset),
        .din(link_connected),
        .dout(link_level)
    );

    // one control bit selects integration testing and detection at once
    always_comb
    begin
        next_mode = mode;
        if (wr_ctrl)
        begin
            case (reg_wdata[`IME_BIT])
                1'b1: next_mode = MODE_DETECT;
                default: next_mode = MODE_FUNC;
            endcase
        end
    end

    // whole-word write; software keeps other bits by read-modify-write
    assign next_out_ovr = wr_ovr ? reg_wdata[NUM_OUT-1:0] : out_ovr;
    assign next_alt_select = sel_take ? sel_req : alt_select;

    // read mux; unmapped addresses return zero
    always_comb
    begin
        if (hit_ctrl)
        begin
            next_rdata = ctrl_word;
        end
        else if (hit_ovr)
        begin
            next_rdata = ovr_word;
        end
        else if (hit_in)
        begin
            next_rdata = in_word;
        end
        else if (hit_link)
        begin
            next_rdata = link_word;
        end
        else if (hit_count)
        begin
            next_rdata = count_word;
        end
        else if (hit_select)
        begin
            next_rdata = select_word;
        end
        else
        begin
            next_rdata = `RST_RDATA;
        end
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            mode <= MODE_FUNC;
            out_ovr <= {NUM_OUT{`RST_OVR}};
            alt_select <= `RST_SELECT;
        end
        else
        begin
            mode <= next_mode;
            out_ovr <= next_out_ovr;
            alt_select <= next_alt_select;
        end
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            reg_rdata <= `RST_RDATA;
        end
        else
        begin
            reg_rdata <= reg_read ? next_rdata : `RST_RDATA;
        end
    end

    // outputs registered; one cycle of skew against functional logic
    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            det_out <= '0;
            func_in <= '0;
            detect_mode <= 1'b0;
        end
        else
        begin
            det_out <= in_detect ? out_ovr : func_out;
            func_in <= in_detect ? '0 : in_level;
            detect_mode <= in_detect;
        end
    end

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (reset);

    in_readback_a:
    assert property (reg_read && hit_in |=> reg_rdata == {{(32-NUM_IN){1'b0}}, $past(in_level)})
    else $error("input level readback wrong");

    ovr_single_a:
    assert property (wr_ovr && in_detect && next_mode == MODE_DETECT
        ##1 in_detect |=> det_out == $past(reg_wdata[NUM_OUT-1:0], 2))
    else $error("override write did not reach output");

    in_isolate_a:
    assert property (in_detect |=> func_in == '0)
    else $error("functional input not isolated");

    out_drive_a:
    assert property (in_detect |=> det_out == $past(out_ovr))
    else $error("output not driven from override");

    in_mode_read_a:
    assert property (in_detect && reg_read && hit_in
        |=> reg_rdata[NUM_IN-1:0] == $past(in_level))
    else $error("detect-mode input read wrong");

    ctrl_read_a:
    assert property (reg_read && hit_ctrl |=> reg_rdata == {31'h0000_0000, $past(in_detect)})
    else $error("mode control readback wrong");

    link_read_a:
    assert property (reg_read && hit_link
        |=> reg_rdata == {{(32-NUM_IN){1'b0}}, $past(link_level)})
    else $error("link status readback wrong");

    select_only_a:
    assert property (!wr_select |=> $stable(alt_select))
    else $error("selection changed without write");

    select_bound_a:
    assert property (alt_count != '0 |-> alt_select < alt_count || $past(alt_count) != alt_count
        || alt_select == `RST_SELECT)
    else $error("selection beyond valid count");

    count_read_a:
    assert property (reg_read && hit_count
        |=> reg_rdata == {{(32-`ALT_W){1'b0}}, $past(alt_count)})
    else $error("count readback wrong");

    select_take_a:
    assert property (wr_select && sel_valid && sel_upper_zero
        |=> alt_select == $past(reg_wdata[`ALT_W-1:0]))
    else $error("valid selection not taken");

    // mode flop then output flop: the pin shows the written bit two edges on
    mode_enable_a:
    assert property (wr_ctrl |=> ##1 detect_mode == $past(reg_wdata[`IME_BIT], 2))
    else $error("mode enable bit misapplied");

    ctrl_mode_a:
    assert property (wr_ctrl |=> in_detect == $past(reg_wdata[`IME_BIT]))
    else $error("mode register did not follow enable bit");

    func_path_a:
    assert property (!in_detect |=> det_out == $past(func_out))
    else $error("functional output path broken");

    select_reject_a:
    assert property (wr_select && !sel_valid |=> $stable(alt_select))
    else $error("out-of-range selection taken");

    rdata_idle_a:
    assert property (!reg_read |=> reg_rdata == `RST_RDATA)
    else $error("read data held past its cycle");

    enter_detect_c:
    cover property (wr_ctrl && reg_wdata[`IME_BIT] ##1 in_detect ##1 det_out == out_ovr);

    probe_c:
    cover property (in_detect && wr_ovr ##2 reg_read && hit_in);

    select_ok_c:
    cover property (sel_take ##1 alt_select != $past(alt_select));

    select_bad_c:
    cover property (wr_select && !sel_valid);

endmodule

// ---- test/far_neighbour.sv ----
`timescale 1ns/1ps

// neighbour that echoes our detection outputs back on our detection inputs;
// slow adds two cycles of lag, flip models inverted wiring on the bits it sets
module far_neighbour (
    input wire logic clk,
    input wire logic reset,
    input wire logic slow,
    input wire logic [3:0] flip,
    input wire logic [3:0] det_out,
    output logic [3:0] det_in
);
    logic [3:0] q1;
    logic [3:0] q2;
    logic [3:0] q3;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            q1 <= 4'h0;
            q2 <= 4'h0;
            q3 <= 4'h0;
        end
        else
        begin
            q1 <= det_out;
            q2 <= q1;
            q3 <= q2;
        end
    end

    assign det_in = (slow ? q3 : q1) ^ flip;
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic slow = 1'b0;
    logic detect_mode;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic [31:0] got;
    logic [3:0] func_in;
    logic [3:0] det_out;
    logic [3:0] det_in;
    logic [3:0] func_out = 4'h0;
    logic [3:0] link_connected = 4'h0;
    logic [3:0] flip = 4'h0;
    logic [3:0] v;
    logic [4:0] alt_count = 5'h06;
    logic [4:0] alt_select;
    logic [4:0] cur;
    logic [31:0] d;
    int errors = 0;
    int checked = 0;
    int cycles = 0;

    always #4 clk = ~clk;

    topo_detect i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .det_in(det_in), .func_in(func_in),
        .func_out(func_out), .det_out(det_out), .link_connected(link_connected),
        .alt_count(alt_count), .alt_select(alt_select), .detect_mode(detect_mode));

    far_neighbour i_far (.clk(clk), .reset(reset), .slow(slow), .flip(flip),
        .det_out(det_out), .det_in(det_in));

    function automatic logic [4:0] exp_sel(input logic [4:0] c, input logic [31:0] w);
        return (w[31:5] == 27'h0 && w[4:0] < alt_count) ? w[4:0] : c;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic stop_test;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        @(posedge clk);
        reg_write <= 1'b1;
        reg_addr <= a;
        reg_wdata <= w;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk);
        reg_read <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, e);
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // generous ceiling: the full sequence needs well under a thousand cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            stop_test();
        end
    end

    initial
    begin
        void'($urandom(32'hFF1E));
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        rdchk(12'hF00, 32'h0);
        rdchk(12'hEF8, 32'h0);
        chk(detect_mode, 1'b0);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            func_out <= 4'($urandom);
            wait_n(1);
            chk(det_out, func_out);
        end
        wr(12'hEF8, 32'hF);
        wait_n(3);
        chk(det_out, func_out);
        wait_n(8);
        chk(func_in, det_in);
        wr(12'hF00, 32'h1);
        wait_n(2);
        chk(detect_mode, 1'b1);
        chk(func_in, 4'h0);
        rdchk(12'hF00, 32'h1);
        v = 4'($urandom);
        // one bit flipped per step so disturbance of neighbours shows
        for (int i = 0; i < 8; i++)
        begin
            v = v ^ (4'h1 << i[1:0]);
            flip <= 4'($urandom);
            slow <= i[0];
            wr(12'hEF8, {28'h0, v});
            func_out <= ~v;
            wait_n(2);
            chk(det_out, v);
            wait_n(8);
            rdchk(12'hEFC, {28'h0, v ^ flip});
        end
        @(posedge clk);
        link_connected <= 4'($urandom);
        wait_n(6);
        rdchk(12'hEF0, {28'h0, link_connected});
        rdchk(12'hEE0, 32'h6);
        wr(12'hEE0, 32'h3);
        rdchk(12'hEE0, 32'h6);
        rdchk(12'h004, 32'h0);
        cur = 5'h00;
        for (int s = 0; s < 36; s++)
        begin
            d = (s < 32) ? 32'(s) : ((s == 32) ? 32'h21 : $urandom);
            wr(12'hEE4, d);
            cur = exp_sel(cur, d);
            wait_n(1);
            chk(alt_select, cur);
            rdchk(12'hEE4, {27'h0, cur});
        end
        // wiring may have moved with the selection, so probe once more
        v = 4'($urandom);
        wr(12'hEF8, {28'h0, v});
        wait_n(10);
        rdchk(12'hEFC, {28'h0, v ^ flip});
        wr(12'hF00, 32'h0);
        func_out <= 4'h9;
        wait_n(2);
        chk(det_out, 4'h9);
        rdchk(12'hEF8, {28'h0, v});
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        rdchk(12'hF00, 32'h0);
        chk(alt_select, 5'h00);
        stop_test();
    end
endmodule
